// ===== verilog/vector_rotation_pio_irq_pkg.sv
package vector_rotation_pio_irq_pkg;

	// data path widths
	localparam int DW    = 12;           // register width
	localparam int AW    = 4;            // address lines
	localparam int PINS  = 6;            // port pins
	localparam int GUARD = 2;            // fraction guard bits inside
	localparam int IW    = 18;           // internal vector width
	localparam int ZW    = 16;           // internal angle width
	localparam int KW    = 17;           // constant coefficient width
	localparam int KFRAC = 15;           // coefficient fraction bits
	localparam int CW    = 6;            // sequence counter width

	// register addresses
	localparam logic [AW-1:0] ADDR_CONTROL   = 4'h0;
	localparam logic [AW-1:0] ADDR_STATUS    = 4'h1;
	localparam logic [AW-1:0] ADDR_PORT_CTRL = 4'h2;
	localparam logic [AW-1:0] ADDR_PORT_DATA = 4'h3;
	localparam logic [AW-1:0] ADDR_PHASE_ONE = 4'h4; // rd phase_voltage_one
	localparam logic [AW-1:0] ADDR_PHASE_TWO = 4'h5; // rd phase_voltage_two
	localparam logic [AW-1:0] ADDR_PHASE_THR = 4'h6; // rd phase_voltage_three
	localparam logic [AW-1:0] ADDR_REV_ANGLE = 4'h7;
	localparam logic [AW-1:0] ADDR_FWD_ANGLE = 4'h8;
	localparam logic [AW-1:0] ADDR_DIRECT_V  = 4'h9; // rd flux_current
	localparam logic [AW-1:0] ADDR_QUAD_V    = 4'ha; // rd torque_current
	localparam logic [AW-1:0] ADDR_CURRENT_X = 4'hb;
	localparam logic [AW-1:0] ADDR_CURRENT_Y = 4'hc;
	localparam logic [AW-1:0] ADDR_VOLTAGE_X = 4'hd;
	localparam logic [AW-1:0] ADDR_VOLTAGE_Y = 4'he;

	// control and status bit positions
	localparam int CTL_VT_IRQ_EN  = 6;
	localparam int CTL_ADC_IRQ_EN = 7;
	localparam int CTL_LEVEL_MODE = 8;
	localparam int CTL_THREE_PH   = 10;
	localparam int ST_ADC         = 0;
	localparam int ST_VT          = 1;
	localparam int ST_PIO         = 2;
	localparam int ST_ANY         = 11;
	localparam int PIO_EN_LSB     = 6;

	// reset values
	localparam logic [DW-1:0] REG_RESET = 12'h000;

	// transformation timing, in system clock cycles
	localparam logic [CW-1:0] REV_CYCLES = 6'h25; // 37
	localparam logic [CW-1:0] FWD_CYCLES = 6'h28; // 40
	localparam logic [CW-1:0] STEP_LOAD  = 6'h00;
	localparam logic [CW-1:0] STEP_PRE   = 6'h01;
	localparam logic [CW-1:0] STEP_ITER  = 6'h02;
	localparam logic [CW-1:0] STEP_GAIN  = 6'h0e; // after 12 iterations

	// fixed point constants, q15
	localparam logic signed [KW-1:0] K_GAIN      = 17'sh04dba; // 0.60725
	localparam logic signed [KW-1:0] K_INV_SQRT3 = 17'sh049e7; // 0.57735
	localparam logic signed [KW-1:0] K_HALF_SQ3  = 17'sh06ed9; // 0.86603
	localparam logic signed [IW-1:0] SAT_MAX     = 18'sh007ff;
	localparam logic signed [IW-1:0] SAT_MIN     = 18'sh3f800;
	localparam logic [ZW-1:0]        Z_HALF      = 16'h8000;
	localparam logic [ZW-DW-1:0]     Z_PAD       = 4'h0;

	typedef enum logic [1:0] {VT_IDLE, VT_REV, VT_FWD} vt_state_t;

	// arctangent of 2^-i in units of 2^16 per turn
	function automatic logic [ZW-1:0] atan_step(input logic [3:0] i);
		case (i)
			4'h0:    return 16'h2000;
			4'h1:    return 16'h12e4;
			4'h2:    return 16'h09fb;
			4'h3:    return 16'h0511;
			4'h4:    return 16'h028b;
			4'h5:    return 16'h0146;
			4'h6:    return 16'h00a3;
			4'h7:    return 16'h0051;
			4'h8:    return 16'h0029;
			4'h9:    return 16'h0014;
			4'ha:    return 16'h000a;
			default: return 16'h0005;
		endcase
	endfunction

endpackage

// ===== verilog/vector_rotation_pio_irq.sv
`timescale 1ns/1ps
// Function
// - reverse angle write starts reverse transformation
// - bit 10 clear: phase one derived
// - reverse results valid 37 cycles later
// - bit 6 enables transformation done event
// - reverse Clarke fills current x and y
// - reverse Park gives flux and torque currents
// - sine and cosine made internally from angle
// - forward needs voltages and angle write, not bit 10
// - forward results valid 40 cycles later
// - forward Park gives voltage x and y
// - forward Clarke gives three phase voltages
// - port control low bits set direction
// - port control high bits enable pin events
// - reset makes pins inputs, events off
// - port data low six bits, rest zero
// - enabled input pin change raises event
// - bit 7 converter, bit 6 transform enables
// - status bit 11 plus source bit set
// - status read clears the four bits
// - request pulse in edge, held in level
// - data twos complement, angles fraction of turn
// - register captured on write strobe rising
module vector_rotation_pio_irq (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [3:0]  addr,
	input  wire logic [11:0] data_in,
	output logic      [11:0] data_out,
	output logic             data_oe,
	input  wire logic [5:0]  pin_in,
	output logic      [5:0]  pin_out,
	output logic      [5:0]  pin_oe,
	input  wire logic        adc_eoc,
	output logic             irq_n_out,
	output logic             irq_oe
);

	localparam int DW = vector_rotation_pio_irq_pkg::DW;
	localparam int IW = vector_rotation_pio_irq_pkg::IW;
	localparam int ZW = vector_rotation_pio_irq_pkg::ZW;
	localparam int KW = vector_rotation_pio_irq_pkg::KW;
	localparam int CW = vector_rotation_pio_irq_pkg::CW;
	localparam int PINS = vector_rotation_pio_irq_pkg::PINS;
	localparam int GUARD = vector_rotation_pio_irq_pkg::GUARD;

	// sign extend a register value and add guard bits
	function automatic logic signed [IW-1:0] ext(input logic [DW-1:0] d);
		return {{(IW-DW-GUARD){d[DW-1]}}, d, {GUARD{1'b0}}};
	endfunction

	// multiply by a q15 constant
	function automatic logic signed [IW-1:0] mulk(
		input logic signed [IW-1:0] a,
		input logic signed [KW-1:0] k);
		logic signed [IW+KW-1:0] p;
		p = a * k;
		p = p >>> vector_rotation_pio_irq_pkg::KFRAC;
		return p[IW-1:0];
	endfunction

	// drop guard bits and clamp to register range
	function automatic logic [DW-1:0] sat(input logic signed [IW-1:0] v);
		logic signed [IW-1:0] s;
		s = v >>> GUARD;
		if (s > vector_rotation_pio_irq_pkg::SAT_MAX)
			s = vector_rotation_pio_irq_pkg::SAT_MAX;
		else if (s < vector_rotation_pio_irq_pkg::SAT_MIN)
			s = vector_rotation_pio_irq_pkg::SAT_MIN;
		return s[DW-1:0];
	endfunction

	logic            wr_n_ff;
	logic            cs_n_ff;
	logic [3:0]      addr_ff;
	logic [DW-1:0]   wdata_ff;
	logic            wr_take;
	logic            rd_stat;
	logic            rd_stat_ff;
	logic            stat_clr;
	logic [DW-1:0]   ctrl_ff;
	logic [DW-1:0]   pctrl_ff;
	logic [PINS-1:0] pout_ff;
	logic [PINS-1:0] pin_prev_ff;
	logic [PINS-1:0] pin_chg;
	logic [PINS-1:0] pin_rd;
	logic [DW-1:0]   ph_cur1_ff;
	logic [DW-1:0]   ph_cur2_ff;
	logic [DW-1:0]   ph_cur3_ff;
	logic [DW-1:0]   rev_angle_ff;
	logic [DW-1:0]   fwd_angle_ff;
	logic [DW-1:0]   dir_volt_ff;
	logic [DW-1:0]   quad_volt_ff;
	logic [DW-1:0]   cur_x_ff;
	logic [DW-1:0]   cur_y_ff;
	logic [DW-1:0]   flux_ff;
	logic [DW-1:0]   torque_ff;
	logic [DW-1:0]   volt_x_ff;
	logic [DW-1:0]   volt_y_ff;
	logic [DW-1:0]   ph_volt1_ff;
	logic [DW-1:0]   ph_volt2_ff;
	logic [DW-1:0]   ph_volt3_ff;
	logic [DW-1:0]   nxt_rdata;
	logic [DW-1:0]   rdata_ff;

	vector_rotation_pio_irq_pkg::vt_state_t state_ff;
	logic [CW-1:0]          cnt_ff;
	logic [CW-1:0]          it_full;
	logic signed [IW-1:0]   x_ff;
	logic signed [IW-1:0]   y_ff;
	logic signed [ZW-1:0]   z_ff;
	logic signed [IW-1:0]   cx_ff;
	logic signed [IW-1:0]   cy_ff;
	logic signed [IW-1:0]   rev_x;
	logic signed [IW-1:0]   rev_y;
	logic signed [IW-1:0]   x_sh;
	logic signed [IW-1:0]   y_sh;
	logic signed [IW-1:0]   half_x;
	logic signed [IW-1:0]   k_y;
	logic [CW-1:0]          last_step;
	logic                   busy;
	logic                   vt_done;

	logic adc_evt;
	logic vt_evt;
	logic pio_evt;
	logic any_evt;
	logic st_adc_ff;
	logic st_vt_ff;
	logic st_pio_ff;
	logic st_any_ff;
	logic edge_ff;

	// sample the host strobes, address and data
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_n_ff  <= 1'b1;
			cs_n_ff  <= 1'b1;
			addr_ff  <= 4'h0;
			wdata_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
		end
		else if (ce)
		begin
			wr_n_ff  <= wr_n;
			cs_n_ff  <= cs_n;
			addr_ff  <= addr;
			wdata_ff <= data_in;
		end
	end

	// write taken on the rising edge of the write strobe
	assign wr_take = ce & wr_n & ~wr_n_ff & ~cs_n_ff;

	// control and port configuration registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_ff  <= vector_rotation_pio_irq_pkg::REG_RESET;
			pctrl_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
			pout_ff  <= '0;
		end
		else if (wr_take)
		begin
			if (addr_ff == vector_rotation_pio_irq_pkg::ADDR_CONTROL)
				ctrl_ff <= wdata_ff;
			if (addr_ff == vector_rotation_pio_irq_pkg::ADDR_PORT_CTRL)
				pctrl_ff <= wdata_ff;
			// only output pins take written data
			if (addr_ff == vector_rotation_pio_irq_pkg::ADDR_PORT_DATA)
				pout_ff <= (pout_ff & ~pctrl_ff[PINS-1:0])
					| (wdata_ff[PINS-1:0] & pctrl_ff[PINS-1:0]);
		end
	end

	// transformation input registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ph_cur1_ff   <= vector_rotation_pio_irq_pkg::REG_RESET;
			ph_cur2_ff   <= vector_rotation_pio_irq_pkg::REG_RESET;
			ph_cur3_ff   <= vector_rotation_pio_irq_pkg::REG_RESET;
			rev_angle_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
			fwd_angle_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
			dir_volt_ff  <= vector_rotation_pio_irq_pkg::REG_RESET;
			quad_volt_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
		end
		else if (wr_take)
		begin
			case (addr_ff)
				vector_rotation_pio_irq_pkg::ADDR_PHASE_ONE: ph_cur1_ff <= wdata_ff;
				vector_rotation_pio_irq_pkg::ADDR_PHASE_TWO: ph_cur2_ff <= wdata_ff;
				vector_rotation_pio_irq_pkg::ADDR_PHASE_THR: ph_cur3_ff <= wdata_ff;
				vector_rotation_pio_irq_pkg::ADDR_REV_ANGLE: rev_angle_ff <= wdata_ff;
				vector_rotation_pio_irq_pkg::ADDR_FWD_ANGLE: fwd_angle_ff <= wdata_ff;
				vector_rotation_pio_irq_pkg::ADDR_DIRECT_V:  dir_volt_ff <= wdata_ff;
				vector_rotation_pio_irq_pkg::ADDR_QUAD_V:    quad_volt_ff <= wdata_ff;
				default: ;
			endcase
		end
	end

	// reverse Clarke terms and rotation step operands
	assign rev_x = ctrl_ff[vector_rotation_pio_irq_pkg::CTL_THREE_PH]
		? ext(ph_cur1_ff)
		: -(ext(ph_cur2_ff) + ext(ph_cur3_ff));
	assign rev_y = mulk(ext(ph_cur3_ff) - ext(ph_cur2_ff),
		vector_rotation_pio_irq_pkg::K_INV_SQRT3);
	assign it_full = cnt_ff - vector_rotation_pio_irq_pkg::STEP_ITER;
	assign x_sh = x_ff >>> it_full[3:0];
	assign y_sh = y_ff >>> it_full[3:0];
	assign half_x = x_ff >>> 1;
	assign k_y = mulk(y_ff, vector_rotation_pio_irq_pkg::K_HALF_SQ3);
	assign busy = (state_ff != vector_rotation_pio_irq_pkg::VT_IDLE);
	assign last_step = (state_ff == vector_rotation_pio_irq_pkg::VT_REV)
		? vector_rotation_pio_irq_pkg::REV_CYCLES - 6'h01
		: vector_rotation_pio_irq_pkg::FWD_CYCLES - 6'h01;
	assign vt_done = ce & busy & (cnt_ff == last_step);

	// sequencer: load, fold into half plane, rotate, remove gain
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_ff <= vector_rotation_pio_irq_pkg::VT_IDLE;
			cnt_ff   <= '0;
			x_ff     <= '0;
			y_ff     <= '0;
			z_ff     <= '0;
			cx_ff    <= '0;
			cy_ff    <= '0;
		end
		else if (ce)
		begin
			case (state_ff)
				vector_rotation_pio_irq_pkg::VT_IDLE:
				begin
					cnt_ff <= '0;
					if (wr_take && addr_ff == vector_rotation_pio_irq_pkg::ADDR_REV_ANGLE)
						state_ff <= vector_rotation_pio_irq_pkg::VT_REV;
					else if (wr_take
						&& addr_ff == vector_rotation_pio_irq_pkg::ADDR_FWD_ANGLE)
						state_ff <= vector_rotation_pio_irq_pkg::VT_FWD;
				end
				vector_rotation_pio_irq_pkg::VT_REV,
				vector_rotation_pio_irq_pkg::VT_FWD:
				begin
					cnt_ff <= cnt_ff + 6'h01;
					if (cnt_ff == last_step)
						state_ff <= vector_rotation_pio_irq_pkg::VT_IDLE;
					if (cnt_ff == vector_rotation_pio_irq_pkg::STEP_LOAD)
					begin
						// reverse rotates by minus the angle, forward by plus
						if (state_ff == vector_rotation_pio_irq_pkg::VT_REV)
						begin
							x_ff  <= rev_x;
							y_ff  <= rev_y;
							cx_ff <= rev_x;
							cy_ff <= rev_y;
							z_ff  <= -{rev_angle_ff, vector_rotation_pio_irq_pkg::Z_PAD};
						end
						else
						begin
							x_ff <= ext(dir_volt_ff);
							y_ff <= ext(quad_volt_ff);
							z_ff <= {fwd_angle_ff, vector_rotation_pio_irq_pkg::Z_PAD};
						end
					end
					else if (cnt_ff == vector_rotation_pio_irq_pkg::STEP_PRE)
					begin
						// angles beyond a quarter turn: rotate half a turn first
						if (z_ff[ZW-1] != z_ff[ZW-2])
						begin
							x_ff <= -x_ff;
							y_ff <= -y_ff;
							z_ff <= z_ff + vector_rotation_pio_irq_pkg::Z_HALF;
						end
					end
					else if (cnt_ff < vector_rotation_pio_irq_pkg::STEP_GAIN)
					begin
						// shift-add rotation; sine and cosine never stored
						if (!z_ff[ZW-1])
						begin
							x_ff <= x_ff - y_sh;
							y_ff <= y_ff + x_sh;
							z_ff <= z_ff - vector_rotation_pio_irq_pkg::atan_step(it_full[3:0]);
						end
						else
						begin
							x_ff <= x_ff + y_sh;
							y_ff <= y_ff - x_sh;
							z_ff <= z_ff + vector_rotation_pio_irq_pkg::atan_step(it_full[3:0]);
						end
					end
					else if (cnt_ff == vector_rotation_pio_irq_pkg::STEP_GAIN)
					begin
						x_ff <= mulk(x_ff, vector_rotation_pio_irq_pkg::K_GAIN);
						y_ff <= mulk(y_ff, vector_rotation_pio_irq_pkg::K_GAIN);
					end
				end
				default: state_ff <= vector_rotation_pio_irq_pkg::VT_IDLE;
			endcase
		end
	end

	// result registers, loaded on the completion cycle only
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cur_x_ff    <= vector_rotation_pio_irq_pkg::REG_RESET;
			cur_y_ff    <= vector_rotation_pio_irq_pkg::REG_RESET;
			flux_ff     <= vector_rotation_pio_irq_pkg::REG_RESET;
			torque_ff   <= vector_rotation_pio_irq_pkg::REG_RESET;
			volt_x_ff   <= vector_rotation_pio_irq_pkg::REG_RESET;
			volt_y_ff   <= vector_rotation_pio_irq_pkg::REG_RESET;
			ph_volt1_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
			ph_volt2_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
			ph_volt3_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
		end
		else if (vt_done && state_ff == vector_rotation_pio_irq_pkg::VT_REV)
		begin
			cur_x_ff  <= sat(cx_ff);
			cur_y_ff  <= sat(cy_ff);
			flux_ff   <= sat(x_ff);
			torque_ff <= sat(y_ff);
		end
		else if (vt_done)
		begin
			volt_x_ff   <= sat(x_ff);
			volt_y_ff   <= sat(y_ff);
			ph_volt1_ff <= sat(x_ff);
			ph_volt2_ff <= sat(-half_x - k_y);
			ph_volt3_ff <= sat(-half_x + k_y);
		end
	end

	// per pin change detect and read value
	genvar g;
	generate
		for (g = 0; g < PINS; g++)
		begin : g_pin
			assign pin_chg[g] = ~pctrl_ff[g]
				& pctrl_ff[vector_rotation_pio_irq_pkg::PIO_EN_LSB + g]
				& (pin_in[g] ^ pin_prev_ff[g]);
			assign pin_rd[g] = pctrl_ff[g] ? pout_ff[g] : pin_in[g];
		end
	endgenerate

	// previous pin levels
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pin_prev_ff <= '0;
		else if (ce)
			pin_prev_ff <= pin_in;
	end

	assign pin_out = pout_ff;
	assign pin_oe  = pctrl_ff[PINS-1:0];

	// interrupt events and end of status read
	assign adc_evt = ce & adc_eoc
		& ctrl_ff[vector_rotation_pio_irq_pkg::CTL_ADC_IRQ_EN];
	assign vt_evt = vt_done
		& ctrl_ff[vector_rotation_pio_irq_pkg::CTL_VT_IRQ_EN];
	assign pio_evt = ce & (|pin_chg);
	assign any_evt = adc_evt | vt_evt | pio_evt;
	assign rd_stat = ~cs_n & ~rd_n
		& (addr == vector_rotation_pio_irq_pkg::ADDR_STATUS);
	assign stat_clr = ce & rd_stat_ff & ~rd_stat;

	// sticky status bits, a new event beats the read clear
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_stat_ff <= 1'b0;
			st_adc_ff  <= 1'b0;
			st_vt_ff   <= 1'b0;
			st_pio_ff  <= 1'b0;
			st_any_ff  <= 1'b0;
			edge_ff    <= 1'b0;
		end
		else if (ce)
		begin
			rd_stat_ff <= rd_stat;
			st_adc_ff  <= adc_evt | (st_adc_ff & ~stat_clr);
			st_vt_ff   <= vt_evt | (st_vt_ff & ~stat_clr);
			st_pio_ff  <= pio_evt | (st_pio_ff & ~stat_clr);
			st_any_ff  <= any_evt | (st_any_ff & ~stat_clr);
			edge_ff    <= any_evt;
		end
	end

	// open drain request: one cycle pulse or held until status read
	assign irq_n_out = 1'b0;
	assign irq_oe = ctrl_ff[vector_rotation_pio_irq_pkg::CTL_LEVEL_MODE]
		? st_any_ff : edge_ff;

	// read data select
	always_comb
	begin
		nxt_rdata = '0;
		case (addr)
			vector_rotation_pio_irq_pkg::ADDR_CONTROL:   nxt_rdata = ctrl_ff;
			vector_rotation_pio_irq_pkg::ADDR_STATUS:
			begin
				nxt_rdata[vector_rotation_pio_irq_pkg::ST_ADC] = st_adc_ff;
				nxt_rdata[vector_rotation_pio_irq_pkg::ST_VT]  = st_vt_ff;
				nxt_rdata[vector_rotation_pio_irq_pkg::ST_PIO] = st_pio_ff;
				nxt_rdata[vector_rotation_pio_irq_pkg::ST_ANY] = st_any_ff;
			end
			vector_rotation_pio_irq_pkg::ADDR_PORT_CTRL: nxt_rdata = pctrl_ff;
			vector_rotation_pio_irq_pkg::ADDR_PORT_DATA:
				nxt_rdata[PINS-1:0] = pin_rd;
			vector_rotation_pio_irq_pkg::ADDR_PHASE_ONE: nxt_rdata = ph_volt1_ff;
			vector_rotation_pio_irq_pkg::ADDR_PHASE_TWO: nxt_rdata = ph_volt2_ff;
			vector_rotation_pio_irq_pkg::ADDR_PHASE_THR: nxt_rdata = ph_volt3_ff;
			vector_rotation_pio_irq_pkg::ADDR_REV_ANGLE: nxt_rdata = rev_angle_ff;
			vector_rotation_pio_irq_pkg::ADDR_FWD_ANGLE: nxt_rdata = fwd_angle_ff;
			vector_rotation_pio_irq_pkg::ADDR_DIRECT_V:  nxt_rdata = flux_ff;
			vector_rotation_pio_irq_pkg::ADDR_QUAD_V:    nxt_rdata = torque_ff;
			vector_rotation_pio_irq_pkg::ADDR_CURRENT_X: nxt_rdata = cur_x_ff;
			vector_rotation_pio_irq_pkg::ADDR_CURRENT_Y: nxt_rdata = cur_y_ff;
			vector_rotation_pio_irq_pkg::ADDR_VOLTAGE_X: nxt_rdata = volt_x_ff;
			vector_rotation_pio_irq_pkg::ADDR_VOLTAGE_Y: nxt_rdata = volt_y_ff;
			default:                                     nxt_rdata = '0;
		endcase
	end

	// registered read data
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata_ff <= vector_rotation_pio_irq_pkg::REG_RESET;
		else if (ce)
			rdata_ff <= nxt_rdata;
	end

	assign data_out = rdata_ff;
	assign data_oe  = ~cs_n & ~rd_n;

endmodule // vector_rotation_pio_irq

// ===== bench/vector_rotation_pio_irq_chk.sv
`timescale 1ns/1ps
// watches bus, port direction and request line of the block
module vector_rotation_pio_irq_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        cs_n,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic [3:0]  addr,
	input wire logic [11:0] data_in,
	input wire logic [11:0] data_out,
	input wire logic [5:0]  pin_oe,
	input wire logic        adc_eoc,
	input wire logic        irq_oe
);
	logic        w_ff;
	logic        c_ff;
	logic [3:0]  a_ff;
	logic [11:0] d_ff;
	logic [11:0] ctl_ff;
	logic [11:0] pctl_ff;
	logic        take;
	logic        rd_st;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// a write lands where the strobe is seen high after a low cycle
	assign take  = wr_n && !w_ff && !c_ff;
	assign rd_st = !cs_n && !rd_n &&
		addr == vector_rotation_pio_irq_pkg::ADDR_STATUS;

	// bus values one cycle back
	always_ff @(posedge clk)
	begin
		w_ff <= wr_n;
		c_ff <= cs_n;
		a_ff <= addr;
		d_ff <= data_in;
	end

	// shadow copies of the two control registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctl_ff  <= 12'h000;
			pctl_ff <= 12'h000;
		end
		else if (take)
		begin
			if (a_ff == vector_rotation_pio_irq_pkg::ADDR_CONTROL)
				ctl_ff <= d_ff;
			if (a_ff == vector_rotation_pio_irq_pkg::ADDR_PORT_CTRL)
				pctl_ff <= d_ff;
		end
	end

	reset_pins_in_a: assert property (
		$rose(rst_n) |-> pin_oe == 6'h00 && !irq_oe)
		else $error("pins or request active after reset");
	dir_follows_ctl_a: assert property (
		pin_oe == pctl_ff[5:0])
		else $error("pin direction differs from port control");
	port_upper_zero_a: assert property (
		$past(addr) == vector_rotation_pio_irq_pkg::ADDR_PORT_DATA
		|-> data_out[11:6] == 6'h00)
		else $error("port data upper bits not zero");
	status_unused_zero_a: assert property (
		$past(addr) == vector_rotation_pio_irq_pkg::ADDR_STATUS
		|-> data_out[10:3] == 8'h00)
		else $error("status unused bits not zero");
	adc_raises_irq_a: assert property (
		adc_eoc && ctl_ff[7] |=> irq_oe)
		else $error("converter event gave no request");
	edge_pulse_one_a: assert property (
		irq_oe && !ctl_ff[8] |=> !irq_oe)
		else $error("edge mode request longer than one cycle");
	level_holds_a: assert property (
		ctl_ff[8] && irq_oe && !rd_st && !$past(rd_st)
		&& !$past(rd_st, 2) |=> irq_oe)
		else $error("level request dropped without status read");
	rev_done_time_a: assert property (
		take && a_ff == 4'h7 && ctl_ff[6]
		|=> !irq_oe [*8] ##30 irq_oe)
		else $error("reverse completion not at cycle 37");
	fwd_done_time_a: assert property (
		take && a_ff == 4'h8 && ctl_ff[6]
		|=> !irq_oe [*8] ##33 irq_oe)
		else $error("forward completion not at cycle 40");
endmodule // vector_rotation_pio_irq_chk

bind vector_rotation_pio_irq vector_rotation_pio_irq_chk u_chk (
	.clk, .rst_n, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out,
	.pin_oe, .adc_eoc, .irq_oe);

// ===== bench/host_bus.sv
`timescale 1ns/1ps
// host processor side of the parallel register port
module host_bus (
	input  wire logic        clk,
	input  wire logic [11:0] data_out,
	output logic             cs_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic      [3:0]  addr,
	output logic      [11:0] data_in
);
	// bus idle from time zero
	initial
	begin
		cs_n    = 1'b1;
		rd_n    = 1'b1;
		wr_n    = 1'b1;
		addr    = 4'h0;
		data_in = 12'h000;
	end

	// write: strobe low one cycle, data held through its rise
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		@(posedge clk);
		cs_n    <= 1'b0;
		wr_n    <= 1'b0;
		addr    <= a;
		data_in <= d;
		@(posedge clk);
		wr_n <= 1'b1;
		@(posedge clk);
		cs_n    <= 1'b1;
		data_in <= ~d; // released bus shows no stale word
		@(posedge clk);
	endtask

	// read: word taken two edges after the strobe falls
	task automatic rd(input logic [3:0] a, output logic [11:0] d);
		@(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		addr <= a;
		@(posedge clk);
		@(posedge clk);
		d = data_out;
		cs_n <= 1'b1;
		rd_n <= 1'b1;
	endtask
endmodule // host_bus

// ===== bench/vector_rotation_pio_irq_tb.sv
`timescale 1ns/1ps
module vector_rotation_pio_irq_tb;
	logic        clk;
	logic        rst_n;
	logic        ce;
	logic        cs_n;
	logic        rd_n;
	logic        wr_n;
	logic [3:0]  addr;
	logic [11:0] data_in;
	logic [11:0] data_out;
	logic        data_oe;
	logic [5:0]  pin_in;
	logic [5:0]  pin_out;
	logic [5:0]  pin_oe;
	logic        adc_eoc;
	logic        irq_n_out;
	logic        irq_oe;
	logic [11:0] rv;
	logic [15:0] lf;
	int          fail_count;
	int          n_tests;

`define CHK(n, e, g) \
	begin \
		n_tests++; \
		if ((e) !== (g)) \
		begin \
			fail_count++; \
			$display("unexpected %s exp %h got %h", n, e, g); \
		end \
	end

	vector_rotation_pio_irq u_vector_rotation_pio_irq (
		.clk, .rst_n, .ce, .cs_n, .rd_n, .wr_n, .addr, .data_in,
		.data_out, .data_oe, .pin_in, .pin_out, .pin_oe, .adc_eoc,
		.irq_n_out, .irq_oe);

	host_bus u_host (
		.clk, .data_out, .cs_n, .rd_n, .wr_n, .addr, .data_in);

	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		fail_count++;
		wrap_up();
	end

	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// sine or cosine of an angle given in 1/4096 turns
	function automatic real tr(input logic [11:0] a, input bit sn);
		real t;
		t = 6.2831853 * a / 4096.0;
		return sn ? $sin(t) : $cos(t);
	endfunction

	function automatic logic near(input real e, input logic [11:0] g);
		real d;
		d = e - $signed(g);
		return d < 8.0 && d > -8.0;
	endfunction

	// reads a result and compares within rotation accuracy
	task automatic rchk(input logic [3:0] a, input real e, input string n);
		logic [11:0] ex;
		e = e > 2047.0 ? 2047.0 : e < -2048.0 ? -2048.0 : e;
		ex = 12'($rtoi(e));
		u_host.rd(a, rv);
		`CHK(n, ex, near(e, rv) ? ex : rv)
	endtask

	task automatic wait_irq();
		int i;
		for (i = 0; i < 100 && irq_oe !== 1'b1; i++)
			@(negedge clk);
		if (i == 100)
		begin
			fail_count++;
			wrap_up();
		end
	endtask

	task automatic done(input string n);
		$display("test %s done", n);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		int i, m, p1, p2, p3;
		logic [11:0] ang;
		logic [5:0] dir;
		real c, s, x, y;
		logic [11:0] ct [3];
		ct = '{12'h080, 12'h180, 12'h000};
		rst_n = 1'b0;
		ce = 1'b1;
		adc_eoc = 1'b0;
		pin_in = 6'h00;
		lf = 16'h50d4;
		fail_count = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		u_host.rd(4'h0, rv);
		`CHK("control", 12'h000, rv)
		u_host.rd(4'h2, rv);
		`CHK("port control", 12'h000, rv)
		@(negedge clk);
		`CHK("request data", 1'b0, irq_n_out)
		`CHK("bus enable", 1'b0, data_oe)
		done("reset");
		for (i = 0; i < 4; i++)
		begin
			lf = lfsr(lf);
			dir = i == 0 ? 6'h3f : lf[5:0];
			pin_in <= lf[15:10];
			u_host.wr(4'h2, {6'h00, dir});
			u_host.wr(4'h3, {6'h00, lf[11:6]});
			u_host.rd(4'h3, rv);
			`CHK("port data", {6'h00, dir & lf[11:6] | ~dir & pin_in}, rv)
			`CHK("pin out", dir & lf[11:6], dir & pin_out)
		end
		done("port");
		u_host.wr(4'h2, 12'hf41);
		pin_in <= pin_in ^ 6'h03;
		repeat (4) @(posedge clk);
		u_host.rd(4'h1, rv);
		`CHK("status", 12'h000, rv)
		pin_in <= pin_in ^ 6'h20;
		repeat (4) @(posedge clk);
		u_host.rd(4'h1, rv);
		`CHK("status", 12'h804, rv)
		u_host.rd(4'h1, rv);
		`CHK("status", 12'h000, rv)
		done("pin events");
		for (m = 0; m < 3; m++)
		begin
			u_host.wr(4'h0, ct[m]);
			@(posedge clk) adc_eoc <= 1'b1;
			@(posedge clk) adc_eoc <= 1'b0;
			@(negedge clk);
			`CHK("irq", m != 2, irq_oe)
			@(negedge clk);
			`CHK("irq", m == 1, irq_oe)
			u_host.rd(4'h1, rv);
			`CHK("status", m == 2 ? 12'h000 : 12'h801, rv)
			repeat (3) @(negedge clk);
			`CHK("irq", 1'b0, irq_oe)
		end
		done("converter events");
		for (i = 0; i < 4; i++)
		begin
			m = i % 2;
			lf = lfsr(lf);
			p1 = int'($signed(lf[9:0]));
			lf = lfsr(lf);
			p2 = int'($signed(lf[9:0]));
			lf = lfsr(lf);
			p3 = int'($signed(lf[9:0]));
			ang = i == 0 ? 12'h000 : lf[15:4];
			u_host.wr(4'h0, m ? 12'h440 : 12'h040);
			u_host.wr(4'h4, 12'(p1));
			u_host.wr(4'h5, 12'(p2));
			u_host.wr(4'h6, 12'(p3));
			u_host.wr(4'h7, ang);
			wait_irq();
			u_host.rd(4'h1, rv);
			`CHK("status", 12'h802, rv)
			x = m ? p1 : -(p2 + p3);
			y = (p3 - p2) / 1.7320508;
			c = tr(ang, 1'b0);
			s = tr(ang, 1'b1);
			rchk(4'hb, x, "current x");
			rchk(4'hc, y, "current y");
			rchk(4'h9, x * c + y * s, "flux");
			rchk(4'ha, y * c - x * s, "torque");
		end
		done("reverse");
		u_host.wr(4'h0, 12'h440);
		for (i = 0; i < 4; i++)
		begin
			lf = lfsr(lf);
			p1 = i == 0 ? 2047 : int'($signed(lf[9:0]));
			lf = lfsr(lf);
			p2 = i == 0 ? 2047 : int'($signed(lf[9:0]));
			ang = i == 0 ? 12'h000 : lf[15:4];
			u_host.wr(4'h9, 12'(p1));
			u_host.wr(4'ha, 12'(p2));
			u_host.wr(4'h8, ang);
			wait_irq();
			u_host.rd(4'h1, rv);
			`CHK("status", 12'h802, rv)
			c = tr(ang, 1'b0);
			s = tr(ang, 1'b1);
			x = p1 * c - p2 * s;
			y = p1 * s + p2 * c;
			rchk(4'hd, x, "voltage x");
			rchk(4'he, y, "voltage y");
			rchk(4'h4, x, "phase one");
			rchk(4'h5, -x / 2 - 0.8660254 * y, "phase two");
			rchk(4'h6, -x / 2 + 0.8660254 * y, "phase three");
		end
		done("forward");
		wrap_up();
	end
endmodule // vector_rotation_pio_irq_tb
